// ### bench/jesd_link_reset_and_lmfc_sync_tb.sv
/*
 Self-checking bench of the reset and multiframe alignment core.
 Assumes one 100 MHz clock and a shortened watchdog limit.
*/
`timescale 1ns/1ps
module jesd_link_reset_and_lmfc_sync_tb import jlrs_pkg::*;;
	logic ref_clk = 0, rst_n = 0, sysRstN = 0, we = 0, cyc = 0, stb = 0;
	logic syncInN = 0, srOn = 0, linkUp = 0, ack, sysref, cgsDone, laneValid;
	logic rxTvalid, syncOutN, txTready, streamRstN;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, datO;
	logic [DATA_W-1:0] txTdata = '0, rxTdata;
	jlrs_oct_t rxOctets, txOctets, prevOct;
	jlrs_tx_e txPhase;
	int num_errors = 0, n_checks = 0;
	jlrs_core #(.WDOG_LIMIT(20'h00040)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .sysRstN(sysRstN),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(datO), .wb_ack_o(ack), .sysref(sysref), .cgsDone(cgsDone), .laneValid(laneValid),
		.rxOctets(rxOctets), .rxTdata(rxTdata), .rxTvalid(rxTvalid), .syncOutN(syncOutN),
		.syncInN(syncInN), .txTdata(txTdata), .txTready(txTready), .txOctets(txOctets),
		.txPhase(txPhase), .streamRstN(streamRstN));
	jlrs_conv_model far (.ref_clk(ref_clk), .srOn(srOn), .linkUp(linkUp), .sysref(sysref),
		.cgsDone(cgsDone), .laneValid(laneValid), .rxOctets(rxOctets));
	initial forever #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) prevOct <= rxOctets;
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tmo(input int i, input int lim);
		if (i >= lim) begin
			num_errors++;
			final_report;
		end
	endtask
	// Classic cycle; the gap cycle is part of the task
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		adr <= a; wdat <= d; we <= w; cyc <= 1; stb <= 1;
		i = 0;
		do begin @(posedge ref_clk); i++; end while (ack !== 1'b1 && i < 20);
		tmo(i, 20);
		rdat = datO;
		cyc <= 0; stb <= 0; we <= 0;
		@(posedge ref_clk);
	endtask
	// Cycles until streamRstN reaches v, sampled settled
	task automatic rst_wait(input logic v, input int lim, output int i);
		i = 0;
		do begin @(posedge ref_clk); #1; i++; end while (streamRstN !== v && i < lim);
		tmo(i, lim);
	endtask
	task t_regs;
		wb(0, OFF_CTRL, 0); check(rdat, 32'h8);
		wb(0, OFF_MFRAME, 0); check(rdat, 32'(RST_MF_LAST));
		wb(0, OFF_SYSREF, 0); check(rdat, 0);
		wb(0, 8'h40, 0); check(rdat, 0);
		wb(1, OFF_CTRL, 32'ha); // Watchdog off until its own test
		wb(1, OFF_SYSREF, 32'h300); wb(0, OFF_SYSREF, 0); check(rdat, 32'h300);
	endtask
	task t_sysreset;
		int i;
		sysRstN <= 0;
		repeat (3) @(posedge ref_clk);
		check(streamRstN, 0); check(syncOutN, 0);
		sysRstN <= 1;
		rst_wait(1, 30, i); check(i, 9);
		wb(0, OFF_SYSREF, 0); check(rdat, 32'h300);
	endtask
	task t_sync;
		int i;
		linkUp <= 1;
		repeat (60) @(posedge ref_clk);
		check(syncOutN, 0); check(rxTvalid, 0);
		srOn <= 1;
		i = 0;
		while (syncOutN !== 1'b1 && i < 100) begin @(posedge ref_clk); i++; end
		tmo(i, 100);
		wb(0, OFF_STATUS, 0); check(rdat[ST_ALIGNED], 1);
		i = 0;
		while (rxTvalid !== 1'b1 && i < 100) begin @(posedge ref_clk); #1; i++; end
		tmo(i, 100);
		for (int l = 0; l < LANES; l++) begin
			for (int k = 0; k < BYTES; k++) begin
				check(rxTdata[l * LANE_W + k * 8 +: 8], prevOct[l][k]);
			end
		end
	endtask
	task t_tx;
		int i;
		@(posedge ref_clk);
		txTdata <= 64'h8877665544332211;
		syncInN <= 1;
		i = 0;
		while (txPhase !== TX_ILA && i < 100) begin @(posedge ref_clk); #1; i++; end
		tmo(i, 100);
		check(txTready, 0);
		i = 0;
		while (txPhase === TX_ILA && i < 100) begin @(posedge ref_clk); #1; i++; end
		tmo(i, 100);
		check(i, 4 * (RST_MF_LAST + 1)); check(txPhase, TX_DATA);
		@(posedge ref_clk); #1;
		check(txTready, 1); check(txOctets, 64'h8877665544332211);
		syncInN <= 0;
		@(posedge ref_clk); #1;
		@(posedge ref_clk); #1;
		check(txPhase, TX_CGS);
	endtask
	task t_soft;
		int i;
		@(posedge ref_clk);
		linkUp <= 0;
		wb(1, OFF_CTRL, 32'hb);
		check(streamRstN, 0);
		wb(0, OFF_SYSREF, 0); check(rdat, 32'h300);
		rst_wait(1, 30, i);
	endtask
	task t_wdog;
		int i, lows;
		@(posedge ref_clk);
		wb(1, OFF_CTRL, 32'h8);
		rst_wait(0, 200, i);
		rst_wait(1, 30, i);
		// Counter restarts from zero at reset end
		rst_wait(0, 200, i); check(i >= 64 && i <= 74, 1);
		@(posedge ref_clk);
		wb(1, OFF_CTRL, 32'ha);
		rst_wait(1, 30, i);
		lows = 0;
		repeat (150) begin @(posedge ref_clk); #1; lows += (streamRstN !== 1'b1); end
		check(lows, 0);
		@(posedge ref_clk);
		wb(1, OFF_SYSREF, 32'h7); wb(0, OFF_SYSREF, 0); check(rdat, 32'h7);
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1;
		sysRstN <= 1;
		@(posedge ref_clk);
		t_regs;
		t_sysreset;
		t_sync;
		t_tx;
		t_soft;
		t_wdog;
		final_report;
	end
endmodule // jesd_link_reset_and_lmfc_sync_tb

// ### bench/jlrs_conv_model.sv
/*
 Far-side converter and sysref source model.
 Assumes ref_clk is the shared device clock.
*/
`timescale 1ns/1ps
module jlrs_conv_model import jlrs_pkg::*; (
	input wire logic ref_clk,
	input wire logic srOn,
	input wire logic linkUp,
	output logic sysref,
	output logic cgsDone,
	output logic laneValid,
	output jlrs_oct_t rxOctets
);
	logic [7:0] cnt;
	initial begin
		cnt = 8'h00;
		sysref = 1'b0;
		cgsDone = 1'b0;
		laneValid = 1'b0;
		rxOctets = '0;
	end
	always @(posedge ref_clk) begin
		cnt <= cnt + 8'h01;
		// Period 16 words: two multiframes, whole words
		sysref <= srOn && (cnt[3:0] == 4'h0);
		cgsDone <= linkUp;
		laneValid <= linkUp;
		// Distinct bytes so a swapped order shows
		for (int l = 0; l < LANES; l++) begin
			for (int k = 0; k < BYTES; k++) begin
				rxOctets[l][k] <= cnt ^ 8'(16 * l + k);
			end
		end
	end
endmodule // jlrs_conv_model

// ### pkg/jlrs_pkg.sv
/*
 Shared constants and types of the link reset and multiframe alignment block.
 Assumes one core clock; the management bus runs on the same clock.
*/
package jlrs_pkg;
	localparam int LANES = 2;
	localparam int BYTES = 4;
	localparam int LANE_W = 32;
	localparam int DATA_W = LANES * LANE_W;
	localparam int WDOG_W = 20;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_SYSREF = 8'h04;
	localparam logic [7:0] OFF_MFRAME = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;

	// Control register bits
	localparam int CTRL_SWRST = 0;
	localparam int CTRL_WDOG_DIS = 1;
	localparam int CTRL_TX_MODE = 2;
	localparam int CTRL_ILA_EN = 3;
	// Sysref handling register fields
	localparam int SR_ALWAYS = 0;
	localparam int SR_RESYNC = 1;
	localparam int SR_POSEDGE = 2;
	localparam int SR_DLY_LSB = 8;
	// Status register fields
	localparam int ST_ALIGNED = 0;
	localparam int ST_SYNC = 1;
	localparam int ST_RELEASE = 2;
	localparam int ST_STREAM = 3;
	localparam int ST_TX_LSB = 4;

	// Reset values
	localparam logic RST_ILA_EN = 1'b1;
	localparam logic [3:0] RST_SR_DLY = 4'h0;
	localparam logic [7:0] RST_MF_LAST = 8'h07;

	// Cycle counts
	localparam logic [3:0] RST_CYCLES = 4'h8;
	localparam logic [1:0] ILA_LAST = 2'h3;

	typedef logic [LANES-1:0][BYTES-1:0][7:0] jlrs_oct_t;

	typedef enum logic [1:0] {TX_CGS, TX_WAIT, TX_ILA, TX_DATA} jlrs_tx_e;

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic wdogDis;
		logic txMode;
		logic ilaEn;
		logic srAlways;
		logic srResync;
		logic srPos;
		logic [3:0] srDly;
		logic [7:0] mfLast;
	} jlrs_cfg_s;

	typedef struct packed {
		logic [3:0] rstCnt;
		logic streamRstN;
		logic [WDOG_W-1:0] wdog;
		logic srSamp;
		logic srPrev;
		logic srPend;
		logic [3:0] srDlyCnt;
		logic [7:0] lmfc;
		logic aligned;
		logic syncOutN;
		logic release_;
		jlrs_tx_e tx;
		logic [1:0] ilaCnt;
		logic [DATA_W-1:0] rxData;
		logic rxValid;
		jlrs_oct_t txOct;
	} jlrs_core_s;

	localparam jlrs_core_s CORE_RST = '{rstCnt: RST_CYCLES, tx: TX_CGS, default: '0};
endpackage

// ### rtl/jlrs_core.sv
/*
 Link reset sequencing, watchdog, sysref capture, multiframe counter,
 receive sync and release gating, transmit start gating, and the register file.
 Assumes classic Wishbone on ref_clk, all link inputs synchronous to ref_clk.
*/
// Our own choices: the Wishbone interface to the registers and the register addresses.
// Operation
// - System reset clears core, keeps registers
// - Management reset restores register defaults
// - Software reset write restarts path, keeps registers
// - Twenty-bit watchdog counts while unsynchronized
// - Watchdog timeout acts like software reset
// - Register bit disables the watchdog
// - Stream reset output low during reset cycle
// - Earliest lane byte in least significant byte
// - Receiver aligns to sysref, then releases sync
// - Multiframe counter marks each multiframe end
// - Transmitter starts on boundary after sync high
// - Receiver releases data at next boundary
// - Sysref sampled on falling edge by default
// - Periodic, one-shot and resync-on-sync-loss sysref options
// - Sync held asserted until sysref alignment
// - Always bit picks every or first event
// - Sysref delay of zero to fifteen cycles
`timescale 1ns/1ps
module jlrs_core import jlrs_pkg::*; #(
	parameter logic [WDOG_W-1:0] WDOG_LIMIT = 20'hfffff
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sysRstN,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sysref,
	input wire logic cgsDone,
	input wire logic laneValid,
	input wire jlrs_oct_t rxOctets,
	output logic [DATA_W-1:0] rxTdata,
	output logic rxTvalid,
	output logic syncOutN,
	input wire logic syncInN,
	input wire logic [DATA_W-1:0] txTdata,
	output logic txTready,
	output jlrs_oct_t txOctets,
	output jlrs_tx_e txPhase,
	output logic streamRstN
);
	jlrs_cfg_s q, d;
	jlrs_core_s c, n;
	logic sysrefNeg_q, sysrefPos_q, srSel, srEvt, srUse, mfEnd;
	logic hit, wrNow, swReq, wdogTo, notSynced;
	logic [3:0] regSel;
	logic [DATA_W-1:0] rxMapped;
	jlrs_oct_t txMapped;

	function automatic logic [3:0] regHit(input logic [7:0] a);
		regHit = {a == OFF_STATUS, a == OFF_MFRAME, a == OFF_SYSREF, a == OFF_CTRL};
	endfunction

	// Falling edge by default gives margin when sysref is edge aligned to the clock
	always_ff @(negedge ref_clk or negedge sysRstN) begin
		if (!sysRstN) begin
			sysrefNeg_q <= 1'b0;
		end else begin
			sysrefNeg_q <= sysref;
		end
	end

	always_ff @(posedge ref_clk or negedge sysRstN) begin
		if (!sysRstN) begin
			sysrefPos_q <= 1'b0;
		end else begin
			sysrefPos_q <= sysref;
		end
	end

	assign srSel = q.srPos ? sysrefPos_q : sysrefNeg_q;

	// Lane byte order
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		for (genvar b = 0; b < BYTES; b++) begin : g_byte
			assign rxMapped[l*LANE_W+b*8 +: 8] = rxOctets[l][b];
			assign txMapped[l][b] = txTdata[l*LANE_W+b*8 +: 8];
		end
	end

	// Management side
	assign hit = wb_cyc_i & wb_stb_i;
	assign regSel = regHit(wb_adr_i);
	assign wrNow = hit & q.ack & wb_we_i;
	assign swReq = wrNow & regSel[0] & wb_sel_i[0] & wb_dat_i[CTRL_SWRST];

	always_comb begin
		d = q;
		d.ack = hit & ~q.ack;
		if (hit & ~q.ack) begin
			d.rdat = '0;
			unique case (1'b1)
				regSel[0]: begin
					d.rdat[CTRL_WDOG_DIS] = q.wdogDis;
					d.rdat[CTRL_TX_MODE] = q.txMode;
					d.rdat[CTRL_ILA_EN] = q.ilaEn;
				end
				regSel[1]: begin
					d.rdat[SR_ALWAYS] = q.srAlways;
					d.rdat[SR_RESYNC] = q.srResync;
					d.rdat[SR_POSEDGE] = q.srPos;
					d.rdat[SR_DLY_LSB +: 4] = q.srDly;
				end
				regSel[2]: begin
					d.rdat[7:0] = q.mfLast;
				end
				regSel[3]: begin
					d.rdat[ST_ALIGNED] = c.aligned;
					d.rdat[ST_SYNC] = c.syncOutN;
					d.rdat[ST_RELEASE] = c.release_;
					d.rdat[ST_STREAM] = c.streamRstN;
					d.rdat[ST_TX_LSB +: 2] = c.tx;
				end
				default: begin
					d.rdat = '0;
				end
			endcase
		end
		// Writes land on the edge that the master sees ack
		if (wrNow && wb_sel_i[0]) begin
			if (regSel[0]) begin
				d.wdogDis = wb_dat_i[CTRL_WDOG_DIS];
				d.txMode = wb_dat_i[CTRL_TX_MODE];
				d.ilaEn = wb_dat_i[CTRL_ILA_EN];
			end
			if (regSel[1]) begin
				d.srAlways = wb_dat_i[SR_ALWAYS];
				d.srResync = wb_dat_i[SR_RESYNC];
				d.srPos = wb_dat_i[SR_POSEDGE];
			end
			if (regSel[2]) begin
				d.mfLast = wb_dat_i[7:0];
			end
		end
		if (wrNow && wb_sel_i[1] && regSel[1]) begin
			d.srDly = wb_dat_i[SR_DLY_LSB +: 4];
		end
	end

	// Registers survive system and software reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{ilaEn: RST_ILA_EN, srDly: RST_SR_DLY, mfLast: RST_MF_LAST, default: '0};
		end else begin
			q <= d;
		end
	end

	// Core side
	assign mfEnd = (c.lmfc == q.mfLast);
	assign srEvt = c.srSamp & ~c.srPrev;
	assign srUse = q.srAlways | ~c.aligned;
	assign notSynced = q.txMode ? ~syncInN : ~c.syncOutN;
	assign wdogTo = (c.wdog == WDOG_LIMIT) & (c.rstCnt == '0);

	always_comb begin
		n = c;
		n.streamRstN = 1'b1;
		n.srSamp = srSel;
		n.srPrev = c.srSamp;
		n.lmfc = mfEnd ? 8'h00 : c.lmfc + 8'h01;
		// Receive sync and resync
		if (!cgsDone) begin
			n.syncOutN = 1'b0;
			if (c.syncOutN && q.srResync) begin
				n.aligned = 1'b0;
			end
		end else if (!c.syncOutN && c.aligned && mfEnd) begin
			n.syncOutN = 1'b1;
		end
		// Sysref alignment with programmable delay
		if (c.srPend) begin
			if (c.srDlyCnt == 4'h1) begin
				n.srPend = 1'b0;
				n.lmfc = 8'h00;
				n.aligned = 1'b1;
			end else begin
				n.srDlyCnt = c.srDlyCnt - 4'h1;
			end
		end
		if (srEvt && srUse) begin
			if (q.srDly == 4'h0) begin
				n.srPend = 1'b0;
				n.lmfc = 8'h00;
				n.aligned = 1'b1;
			end else begin
				n.srPend = 1'b1;
				n.srDlyCnt = q.srDly;
			end
		end
		// Receive release waits for a boundary so latency is repeatable
		if (!laneValid) begin
			n.release_ = 1'b0;
		end else if (c.syncOutN && mfEnd) begin
			n.release_ = 1'b1;
		end
		n.rxData = c.release_ ? rxMapped : '0;
		n.rxValid = c.release_;
		// Transmit start
		unique case (c.tx)
			TX_CGS: begin
				if (syncInN && c.aligned) begin
					n.tx = TX_WAIT;
				end
			end
			TX_WAIT: begin
				if (mfEnd) begin
					n.tx = q.ilaEn ? TX_ILA : TX_DATA;
					n.ilaCnt = 2'h0;
				end
			end
			TX_ILA: begin
				if (mfEnd) begin
					if (c.ilaCnt == ILA_LAST) begin
						n.tx = TX_DATA;
					end else begin
						n.ilaCnt = c.ilaCnt + 2'h1;
					end
				end
			end
			TX_DATA: begin
				n.tx = TX_DATA;
			end
		endcase
		if (!syncInN) begin
			n.tx = TX_CGS;
		end
		n.txOct = (c.tx == TX_DATA) ? txMapped : '0;
		// Watchdog; only a continuous loss of sync reaches the limit
		if (q.wdogDis || !notSynced) begin
			n.wdog = '0;
		end else begin
			n.wdog = c.wdog + 20'h00001;
		end
		// Reset cycle, software and watchdog alike
		if (swReq || wdogTo) begin
			n = CORE_RST;
			n.srSamp = srSel;
		end else if (c.rstCnt != 4'h0) begin
			n = CORE_RST;
			n.rstCnt = c.rstCnt - 4'h1;
			n.srSamp = srSel;
		end
	end

	always_ff @(posedge ref_clk or negedge sysRstN) begin
		if (!sysRstN) begin
			c <= CORE_RST;
		end else begin
			c <= n;
		end
	end

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdat;
	assign rxTdata = c.rxData;
	assign rxTvalid = c.rxValid;
	assign syncOutN = c.syncOutN;
	assign txOctets = c.txOct;
	assign txPhase = c.tx;
	assign txTready = (c.tx == TX_DATA);
	assign streamRstN = c.streamRstN;

	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!sysRstN || !rst_n);

	logic idle;
	assign idle = (c.rstCnt == 4'h0) & ~swReq & ~wdogTo;

	property p_swrst;
		swReq |=> !streamRstN [*8];
	endproperty
	a_swrst: assert property (p_swrst) else $error("stream reset not held after soft reset");

	property p_wdog_inc;
		(idle && !q.wdogDis && notSynced) |=> (c.wdog == $past(c.wdog) + 20'h00001);
	endproperty
	a_wdog_inc: assert property (p_wdog_inc) else $error("watchdog did not count");

	property p_wdog_to;
		wdogTo |=> (c.rstCnt == RST_CYCLES) && !streamRstN;
	endproperty
	a_wdog_to: assert property (p_wdog_to) else $error("watchdog timeout gave no reset");

	property p_wdog_clr;
		(q.wdogDis || !notSynced) |=> (c.wdog == '0);
	endproperty
	a_wdog_clr: assert property (p_wdog_clr) else $error("watchdog not cleared");

	property p_sync_rise;
		$rose(syncOutN) |-> c.aligned && $past(mfEnd) && $past(cgsDone);
	endproperty
	a_sync_rise: assert property (p_sync_rise) else $error("sync released without alignment");

	property p_lmfc_wrap;
		mfEnd |=> (c.lmfc == 8'h00);
	endproperty
	a_lmfc_wrap: assert property (p_lmfc_wrap) else $error("multiframe counter did not wrap");

	property p_tx_hold;
		(idle && c.tx == TX_WAIT && !mfEnd && syncInN) |=> (c.tx == TX_WAIT);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("transmit left wait off boundary");

	property p_release;
		$rose(c.release_) |-> $past(mfEnd) && $past(laneValid);
	endproperty
	a_release: assert property (p_release) else $error("release off boundary");

	property p_sr_now;
		(idle && srEvt && srUse && q.srDly == 4'h0) |=> (c.lmfc == 8'h00) && c.aligned;
	endproperty
	a_sr_now: assert property (p_sr_now) else $error("sysref did not realign");

	property p_sr_ignore;
		(idle && srEvt && !srUse && !c.srPend) |=> !c.srPend;
	endproperty
	a_sr_ignore: assert property (p_sr_ignore) else $error("sysref used while always is clear");

	property p_byte_order;
		(idle && c.release_) |=> (rxTdata[7:0] == $past(rxOctets[0][0])) && rxTvalid;
	endproperty
	a_byte_order: assert property (p_byte_order) else $error("lane byte order wrong");

	c_sync: cover property ($rose(syncOutN));
	c_tx_data: cover property (c.tx == TX_ILA ##1 c.tx == TX_DATA);
	c_release: cover property ($rose(c.release_));
	c_wdog: cover property (wdogTo);
endmodule // jlrs_core
